// ==== hdl/dda_pkg.sv ====
// Package of constants and types for the decrement and decimal adjust datapath
package dda_pkg;
	localparam int DDA_DATA_W = 8;
	localparam int DDA_ADDR_W = 12;
	localparam int DDA_BANK_W = 4;
	localparam int DDA_OPC_W = 16;
	// Instruction encodings
	localparam logic [15:0] DDA_DECIMAL_ADJUST_OP = 16'h0007;
	localparam logic [5:0] DDA_DECREMENT_FILE_OP = 6'h01;
	localparam int DDA_OPC_HI_POS = 10;
	localparam int DDA_D_POS = 9;
	localparam int DDA_A_POS = 8;
	// Access bank split: low half maps to bank 0, high half to the top bank
	localparam logic [7:0] DDA_ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] DDA_ACCESS_HI_BANK = 4'hF;
	localparam logic [3:0] DDA_BCD_LIMIT = 4'h9;
	localparam logic [3:0] DDA_BCD_FIX = 4'h6;
	localparam logic [7:0] DDA_RESET_BYTE = 8'h00;
	localparam logic [4:0] DDA_RESET_FLAGS = 5'h00;
	// Flag positions in the status vector
	localparam int DDA_FLAG_C = 0;
	localparam int DDA_FLAG_DC = 1;
	localparam int DDA_FLAG_Z = 2;
	localparam int DDA_FLAG_OV = 3;
	localparam int DDA_FLAG_N = 4;
	typedef enum logic [1:0] {DDA_Q1, DDA_Q2, DDA_Q3, DDA_Q4} dda_phase_t;
endpackage : dda_pkg

// ==== hdl/dda_phase_gen.sv ====
// Four-phase instruction cycle sequencer
`timescale 1ns/100ps
module dda_phase_gen
	import dda_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n_sync, // Synchronised reset, active low
	output dda_phase_t phase // Current phase
);
	// Free-running phase counter, wraps Q4 to Q1
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			phase <= DDA_Q1;
		else
			case (phase)
				DDA_Q1: phase <= DDA_Q2;
				DDA_Q2: phase <= DDA_Q3;
				DDA_Q3: phase <= DDA_Q4;
				DDA_Q4: phase <= DDA_Q1;
				default: phase <= DDA_Q1;
			endcase
	end
endmodule : dda_phase_gen

// ==== hdl/dda_core.sv ====
// Decrement-file and decimal-adjust datapath with four-phase instruction cycle
// One instruction every four clocks: Q1 decode, Q2 read, Q3 process, Q4 write.
// Nothing latches the instruction word, so it must stay put for all four phases.
// Strobes and the retire pulse show in the Q1 cycle after the Q4 edge.
// Reset release lags by two clocks; phases restart at Q1 after it.
`timescale 1ns/100ps
module dda_core
	import dda_pkg::*;
(
	input wire logic clk, // Core clock, 100 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic [dda_pkg::DDA_OPC_W-1:0] instr, // Instruction word, held for the cycle
	input wire logic instr_valid, // Instruction present at Q1
	input wire logic [dda_pkg::DDA_BANK_W-1:0] bank_select_reg, // Current bank select value
	input wire logic [dda_pkg::DDA_DATA_W-1:0] file_rdata, // File read data for file_addr
	input wire logic [4:0] flags_in, // Current status flags
	output logic [dda_pkg::DDA_ADDR_W-1:0] file_addr, // File register address
	output logic file_we, // File write strobe, one cycle, in the Q1 cycle after the Q4 edge
	output logic [dda_pkg::DDA_DATA_W-1:0] file_wdata, // File write data
	output logic [dda_pkg::DDA_DATA_W-1:0] wreg, // Working register
	output logic [4:0] flags_out, // Status flags after execution
	output logic flags_we, // Flag update strobe, one cycle, in the Q1 cycle after the Q4 edge
	output logic [1:0] q_phase, // Phase now: 0=Q1 .. 3=Q4
	output logic done // Instruction retired, one cycle
);
	import dda_pkg::*;

	logic rst_meta;
	logic rst_n_sync;
	dda_phase_t phase;
	logic op_dec;
	logic op_daw;
	logic dest_file;
	logic [DDA_DATA_W-1:0] operand;
	logic [DDA_DATA_W-1:0] next_result;
	logic [4:0] next_flags;
	logic [DDA_DATA_W-1:0] result;
	logic [4:0] result_flags;
	logic [DDA_ADDR_W-1:0] next_addr;
	logic retire;
	wire logic [DDA_DATA_W/4:0] daw_carry;
	wire logic [DDA_DATA_W-1:0] daw_result;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta <= 1'b0;
			rst_n_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n_sync <= rst_meta;
		end
	end

	dda_phase_gen u_dda_phase_gen (
		.clk(clk),
		.rst_n_sync(rst_n_sync),
		.phase(phase)
	);

	// Decode stage fields
	always_comb
	begin
		op_dec = instr_valid && (instr[DDA_OPC_W-1:DDA_OPC_HI_POS] == DDA_DECREMENT_FILE_OP);
		op_daw = instr_valid && (instr == DDA_DECIMAL_ADJUST_OP);
		dest_file = instr[DDA_D_POS];
	end

	// Operand address: access bank splits at 0x80 so both ends of memory stay reachable
	always_comb
	begin
		if (instr[DDA_A_POS])
			next_addr = {bank_select_reg, instr[7:0]};
		else if (instr[7:0] < DDA_ACCESS_SPLIT)
			next_addr = {4'h0, instr[7:0]};
		else
			next_addr = {DDA_ACCESS_HI_BANK, instr[7:0]};
	end

	// Decimal adjust, one pass per nibble; the +6 carry ripples upward as in a BCD adder
	assign daw_carry[0] = 1'b0;
	generate
		for (genvar g = 0; g < DDA_DATA_W / 4; g++)
		begin : g_nibble
			// Low nibble answers to the digit carry, high nibble to the carry
			localparam int CARRY_FLAG = (g == 0) ? DDA_FLAG_DC : DDA_FLAG_C;
			logic [4:0] raw_sum;
			logic [4:0] fixed_sum;
			assign raw_sum = {1'b0, operand[4 * g + 3 -: 4]} + {4'h0, daw_carry[g]};
			assign fixed_sum = ((raw_sum > {1'b0, DDA_BCD_LIMIT}) || flags_in[CARRY_FLAG]) ?
				raw_sum + {1'b0, DDA_BCD_FIX} : raw_sum;
			assign daw_result[4 * g + 3 -: 4] = fixed_sum[3:0];
			assign daw_carry[g + 1] = fixed_sum[4];
		end
	endgenerate

	// Arithmetic for both instructions; only one is live per cycle
	always_comb
	begin
		next_result = operand;
		next_flags = flags_in;
		if (op_dec)
		begin
			next_result = operand - 8'h01;
			// Borrow convention: C and DC clear only when a borrow occurs
			next_flags[DDA_FLAG_C] = (operand != DDA_RESET_BYTE);
			next_flags[DDA_FLAG_DC] = (operand[3:0] != 4'h0);
			next_flags[DDA_FLAG_Z] = (next_result == DDA_RESET_BYTE);
			next_flags[DDA_FLAG_N] = next_result[DDA_DATA_W-1];
			next_flags[DDA_FLAG_OV] = (operand == 8'h80);
		end
		else if (op_daw)
		begin
			next_result = daw_result;
			// Carry sticks once set, as a decimal carry out of the byte
			next_flags[DDA_FLAG_C] = daw_carry[DDA_DATA_W / 4] || flags_in[DDA_FLAG_C];
		end
	end

	// Retirement only for a recognised word at Q4; refused words write nothing
	assign retire = (phase == DDA_Q4) && (op_dec || op_daw);

	// Address latched at the Q1 edge so the read phase sees it settled
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			file_addr <= '0;
		else if (phase == DDA_Q1)
			file_addr <= next_addr;
	end

	// Operand taken at the Q2 edge: working register for decimal adjust, file data otherwise
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			operand <= DDA_RESET_BYTE;
		else if (phase == DDA_Q2)
			operand <= op_daw ? wreg : file_rdata;
	end

	// Result and flags parked at the Q3 edge, so the write phase drives from flops
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			result <= DDA_RESET_BYTE;
			result_flags <= DDA_RESET_FLAGS;
		end
		else if (phase == DDA_Q3)
		begin
			result <= next_result;
			result_flags <= next_flags;
		end
	end

	// Working register takes decrement with destination 0, or the decimal adjust
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			wreg <= DDA_RESET_BYTE;
		else if (retire && !(op_dec && dest_file))
			wreg <= result;
	end

	// File write strobe lasts one cycle; data holds between writes
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			file_we <= 1'b0;
			file_wdata <= DDA_RESET_BYTE;
		end
		else
		begin
			file_we <= retire && op_dec && dest_file;
			if (retire && op_dec && dest_file)
				file_wdata <= result;
		end
	end

	// Flags leave on every retirement; decimal adjust passes all but carry through
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			flags_out <= DDA_RESET_FLAGS;
			flags_we <= 1'b0;
		end
		else
		begin
			flags_we <= retire;
			if (retire)
				flags_out <= result_flags;
		end
	end

	// Retire pulse, one cycle, single instruction cycle total
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			done <= 1'b0;
		else
			done <= retire;
	end

	// Phase shown outside for the surrounding core
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			q_phase <= 2'h0;
		else
			q_phase <= phase + 2'h1;
	end
endmodule : dda_core

// ==== verif/dda_core_properties.sv ====
// Checker of retire timing, destination and address forming
`timescale 1ns/100ps
module dda_core_properties
	import dda_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_b, // Reset, active low
	input wire logic [15:0] instr, // Instruction word
	input wire logic instr_valid, // Instruction present
	input wire logic [3:0] bank_select_reg, // Bank select
	input wire logic [7:0] file_rdata, // File read data
	input wire logic [11:0] file_addr, // File address
	input wire logic file_we, // File write strobe
	input wire logic [7:0] file_wdata, // File write data
	input wire logic [7:0] wreg, // Working register
	input wire logic [1:0] q_phase, // Phase now
	input wire logic done // Retire pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Decoded in the read phase, where the operand is taken
	wire dec = instr_valid && q_phase == 2'h1 && instr[15:10] == DDA_DECREMENT_FILE_OP;
	AST_DEC_ONE_CYCLE: assert property (dec |-> !done ##1 !done ##1 !done ##1 done)
		else $error("decrement not retired in one cycle");
	AST_DEC_TO_W: assert property (dec && !instr[DDA_D_POS] |->
		##3 !file_we && wreg == $past(file_rdata, 3) - 8'h01)
		else $error("decrement to working register wrong");
	AST_DEC_TO_F: assert property (dec && instr[DDA_D_POS] |->
		##3 file_we && file_wdata == $past(file_rdata, 3) - 8'h01)
		else $error("decrement writeback wrong");
	AST_ACCESS_BANK: assert property (dec && !instr[DDA_A_POS] |->
		file_addr == {instr[7] ? DDA_ACCESS_HI_BANK : 4'h0, instr[7:0]})
		else $error("access bank address wrong");
	AST_BSR_BANK: assert property (dec && instr[DDA_A_POS] |->
		file_addr == {$past(bank_select_reg), instr[7:0]})
		else $error("banked address wrong");
	AST_DAW_RETIRE: assert property (instr_valid && q_phase == 2'h1 && instr == DDA_DECIMAL_ADJUST_OP |->
		##3 done && !file_we)
		else $error("decimal adjust retire wrong");
	AST_DONE_IN_Q1: assert property (done |-> q_phase == 2'h0)
		else $error("retire pulse outside the decode phase");
endmodule : dda_core_properties

// ==== verif/tb_top.sv ====
// Self-checking bench of the datapath
`timescale 1ns/100ps
module tb_top;
	import dda_pkg::*;
	logic clk = 0, rst_b = 0, instr_valid = 0, file_we, flags_we, done;
	logic [15:0] instr = 16'h0000;
	logic [3:0] bank_select_reg = 4'h0;
	logic [7:0] file_rdata = 8'h00, wreg, file_wdata, w = 8'h00;
	logic [7:0] dv [4] = '{8'hA5, 8'hCE, 8'h42, 8'h19};
	logic [4:0] flags_in = 5'h00, flags_out;
	logic [11:0] file_addr;
	logic [1:0] q_phase;
	logic [31:0] seed = 32'h6412, x;
	logic [35:0] expq [$], e;
	int error_cnt = 0, checks = 0;
	always #5 clk = ~clk;
	dda_core u_dda_core (.clk(clk), .rst_b(rst_b), .instr(instr), .instr_valid(instr_valid),
		.bank_select_reg(bank_select_reg), .file_rdata(file_rdata), .flags_in(flags_in), .file_addr(file_addr),
		.file_we(file_we), .file_wdata(file_wdata), .wreg(wreg), .flags_out(flags_out), .flags_we(flags_we),
		.q_phase(q_phase), .done(done));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task check(input string n, input logic [35:0] s, input logic [35:0] t);
		checks++;
		if (s !== t)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp=%h seen=%h", n, t, s);
		end
	endtask : check
	// Present at Q1 and hold all four phases; note what retirement must show
	task run(input logic [15:0] op, input logic v, input logic [7:0] rd);
		logic [7:0] r;
		logic [8:0] t;
		logic [31:0] y;
		y = rnd();
		r = rd - 8'h01;
		@(posedge clk);
		while (q_phase !== 2'h3) @(posedge clk);
		instr <= op;
		instr_valid <= v;
		file_rdata <= rd;
		bank_select_reg <= y[3:0];
		flags_in <= y[8:4];
		if (v && op[15:10] == DDA_DECREMENT_FILE_OP)
		begin
			w = op[DDA_D_POS] ? w : r;
			expq.push_back({1'b1, op[DDA_D_POS], 1'b1, w, op[DDA_D_POS] ? r : 8'h00, r[7], rd == 8'h80, r == 8'h00,
				rd[3:0] != 4'h0, rd != 8'h00, op[DDA_A_POS] ? y[3:0] : (op[7] ? 4'hF : 4'h0), op[7:0]});
		end
		else if (v && op == DDA_DECIMAL_ADJUST_OP)
		begin
			t = {1'b0, w};
			if (t[3:0] > 4'h9 || y[5]) t = t + 9'h006;
			if (t[8:4] > 5'h09 || y[4]) t = t + 9'h060;
			w = t[7:0];
			expq.push_back({3'b001, w, 8'h00, y[8:5], t[8] | y[4], 12'h000});
		end
	endtask : run
	// Compare oldest note at each retirement; address only for decrement
	always @(posedge clk)
		if (done === 1'b1)
		begin
			e = expq.size() ? expq.pop_front() : 36'hF_FFFF_FFFF;
			check("result", {e[35], file_we, flags_we, wreg, file_we ? file_wdata : 8'h00, flags_out,
				e[35] ? file_addr : 12'h000}, e);
		end
	task summarize();
		$display("error_cnt=%0d checks=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 24; i++)
		begin
			x = rnd();
			run({DDA_DECREMENT_FILE_OP, x[1:0], x[31:24]}, 1'b1, x[23:16]);
		end
		run(DDA_DECIMAL_ADJUST_OP, 1'b0, 8'h00);
		run(16'hFFFF, 1'b1, 8'h00);
		run({DDA_DECREMENT_FILE_OP, 2'b01, 8'hFF}, 1'b1, 8'h00);
		foreach (dv[i])
		begin
			run({DDA_DECREMENT_FILE_OP, 2'b00, 8'h10}, 1'b1, dv[i] + 8'h01);
			run(DDA_DECIMAL_ADJUST_OP, 1'b1, 8'h00);
		end
		run(16'h0000, 1'b0, 8'h00);
		repeat (8) @(posedge clk);
		check("pending", expq.size(), 0);
		summarize();
	end
	// Hang guard well beyond the fewer than two hundred cycles used
	initial
	begin
		#20000;
		check("timeout", 1, 0);
		summarize();
	end
endmodule : tb_top
bind dda_core dda_core_properties u_dda_core_properties (.clk(clk), .rst_b(rst_b), .instr(instr),
	.instr_valid(instr_valid), .bank_select_reg(bank_select_reg), .file_rdata(file_rdata), .file_addr(file_addr),
	.file_we(file_we), .file_wdata(file_wdata), .wreg(wreg), .q_phase(q_phase), .done(done));
